// ### tb/bcd_rtc_with_nibble_cpu_port_bench.sv
// ==========================================================
// Self-checking bench
// ==========================================================
module bcd_rtc_with_nibble_cpu_port_bench;
  import rtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] a; logic [3:0] d; logic [3:0] e;} row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic xtal_in = 1'b0;
  int xcnt = 0;
  int fail_count = 0;
  int n_tests = 0;
  logic cs_n, ce, rd_n, wr_n, data_oe, irq_out_n, timer_out_n, xtal_out;
  logic [3:0] addr_in, data_in, data_out;
  row_s rows[9] = '{'{OFS_MIN1, 4'h7, 4'h7}, '{OFS_MIN10, 4'h5, 4'h5},
    '{OFS_DOW, 4'h3, 4'h3}, '{OFS_YR1, 4'h9, 4'h9}, '{OFS_MODE, 4'h1, 4'h1},
    '{OFS_CTRL, 4'h1, 4'h1}, '{OFS_MIN1, 4'h9, 4'h9}, '{4'h6, 4'h5, 4'h0},
    '{OFS_CTRL, 4'h0, 4'h0}};

  // Clock and a fast crystal stand-in, so that timer ticks fall inside the run.
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    xcnt <= (xcnt == 7) ? 0 : xcnt + 1;
    if (xcnt == 7) xtal_in <= ~xtal_in;
  end

  cpu_port_model cpu (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
    .cs_n(cs_n), .ce(ce), .rd_n(rd_n), .wr_n(wr_n), .addr_in(addr_in), .data_in(data_in));
  bcd_rtc_with_nibble_cpu_port dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .ce(ce),
    .rd_n(rd_n), .wr_n(wr_n), .addr_in(addr_in), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .irq_out_n(irq_out_n), .timer_out_n(timer_out_n),
    .xtal_in(xtal_in), .xtal_out(xtal_out));

  // Compare helpers and the closing report.
  task automatic chk(input logic [3:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, d, input logic sn = 1'b0, pw = 1'b1);
    logic [3:0] q;
    logic s;
    cpu.xfer(1'b1, sn, pw, a, d, q, s);
  endtask
  task automatic rd_chk(input logic [3:0] a, e, input logic sn = 1'b0, pw = 1'b1);
    logic [3:0] q;
    logic s;
    cpu.xfer(1'b0, sn, pw, a, 4'h0, q, s);
    chk({3'h0, s}, {3'h0, !sn && pw});
    if (s !== (!sn && pw)) wrap_up();
    if (s) chk(q, e);
  endtask
  task automatic adj(input logic [3:0] t, u, m);
    wr(OFS_SEC10, t);
    wr(OFS_SEC1, u);
    wr(OFS_CTRL, 4'h2);
    rd_chk(OFS_MIN1, m);
    rd_chk(OFS_SEC1, 4'h0);
    rd_chk(OFS_SEC10, 4'h0);
    rd_chk(OFS_CTRL, 4'h0);
  endtask

  // Main sequence: table of accesses, then the awkward cases.
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    wr(OFS_MIN1, 4'h2, 1'b1);
    rd_chk(OFS_MIN1, 4'h0, 1'b1);
    wr(OFS_MIN1, 4'h3, 1'b0, 1'b0);
    chk({3'h0, timer_out_n}, 4'h1);
    rd_chk(OFS_MIN1, 4'h7);
    adj(4'h4, 4'h0, 4'h8);
    adj(4'h2, 4'h9, 4'h8);
    chk({2'h0, irq_out_n, timer_out_n}, 4'h3);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(OFS_MIN1, 4'h0);
    rd_chk(OFS_MODE, MODE_RST);
    rd_chk(OFS_STAT, 4'h1);
    // Leap day: 23:59:30 on the 28th of February, year 00, rounds into the 29th.
    wr(OFS_HR10, 4'h2);
    wr(OFS_HR1, 4'h3);
    wr(OFS_MIN10, 4'h5);
    wr(OFS_MIN1, 4'h9);
    wr(OFS_MON1, 4'h2);
    wr(OFS_DAY10, 4'h2);
    wr(OFS_DAY1, 4'h8);
    adj(4'h3, 4'h0, 4'h0);
    rd_chk(OFS_HR10, 4'h0);
    rd_chk(OFS_DAY1, 4'h9);
    rd_chk(OFS_DAY10, 4'h2);
    // Alarm at 00:01 pulls the interrupt low, and it survives chip enable low.
    wr(OFS_CTRL, 4'h1);
    wr(OFS_SEC1, 4'h1);
    wr(OFS_MODE, 4'h9);
    wr(OFS_CTRL, 4'h0);
    adj(4'h3, 4'h0, 4'h1);
    chk({3'h0, irq_out_n}, 4'h0);
    rd_chk(OFS_STAT, 4'h3);
    wr(OFS_MIN1, 4'h0, 1'b0, 1'b0);
    chk({3'h0, irq_out_n}, 4'h0);
    wr(OFS_CTRL, 4'h4);
    chk({3'h0, irq_out_n}, 4'h1);
    wr(OFS_STAT, 4'h2);
    rd_chk(OFS_STAT, 4'h1);
    // Periodic timer with reload zero fires on a tick, then halts without chip enable.
    wr(OFS_CTRL, 4'h1);
    wr(OFS_TMR_LO, 4'h0);
    wr(OFS_TMR_HI, 4'h0);
    wr(OFS_CTRL, 4'h8);
    for (int i = 0; i < 20000 && timer_out_n; i++) @(posedge sys_clk);
    chk({3'h0, timer_out_n}, 4'h0);
    wr(OFS_MIN1, 4'h0, 1'b0, 1'b0);
    chk({3'h0, timer_out_n}, 4'h1);
    wrap_up();
  end
endmodule // bcd_rtc_with_nibble_cpu_port_bench

bind bcd_rtc_with_nibble_cpu_port rtc_bus_monitor mon (.sys_clk(sys_clk), .rst(rst),
  .cs_n(cs_n), .ce(ce), .rd_n(rd_n), .data_out(data_out), .data_oe(data_oe),
  .timer_out_n(timer_out_n), .xtal_in(xtal_in), .xtal_out(xtal_out));

// ### tb/cpu_port_model.sv
// ==========================================================
// Processor bus model
// ==========================================================
module cpu_port_model (
  // Clock and device answer.
  input wire logic sys_clk,
  input wire logic [3:0] data_out,
  input wire logic data_oe,
  // Lines toward the device.
  output logic cs_n,
  output logic ce,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] addr_in,
  output logic [3:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_q;
  logic [3:0] val_q;

  // Wire level: device first, then this model, else a floating pattern.
  assign data_in = data_oe ? data_out : (drv_q ? val_q : ~val_q);

  // Idle bus at time zero.
  initial begin
    cs_n = 1'b1;
    ce = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr_in = 4'h0;
    drv_q = 1'b0;
    val_q = 4'h0;
  end

  // One access; selects are set up long before the strobe and held after it.
  task automatic xfer(input logic wr, sn, pw, input logic [3:0] a, d,
                      output logic [3:0] q, output logic seen);
    q = 4'h0;
    seen = 1'b0;
    @(posedge sys_clk);
    cs_n <= sn;
    ce <= pw;
    addr_in <= a;
    val_q <= d;
    drv_q <= wr;
    repeat (8) @(posedge sys_clk);
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      if (data_oe === 1'b1) begin
        q = data_out;
        seen = 1'b1;
      end
    end
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    cs_n <= 1'b1;
    drv_q <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // cpu_port_model

// ### tb/rtc_bus_monitor.sv
// ==========================================================
// Port checker for the clock chip processor port
// ==========================================================
module rtc_bus_monitor (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Processor port.
  input wire logic cs_n,
  input wire logic ce,
  input wire logic rd_n,
  input wire logic [3:0] data_out,
  input wire logic data_oe,
  // Timer and oscillator.
  input wire logic timer_out_n,
  input wire logic xtal_in,
  input wire logic xtal_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks share one clock and one reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RD_IDLE: assert property (rd_n [*8] |=> !data_oe)
    else $error("data lines driven without read");
  AST_CS_IDLE: assert property (cs_n [*8] |=> !data_oe)
    else $error("data lines driven without select");
  AST_CE_LOW: assert property (!ce [*8] |=> !data_oe && $stable(data_out))
    else $error("read taken while enable low");
  AST_TMR_OFF: assert property (!ce [*8] |=> timer_out_n)
    else $error("timer active while enable low");
  AST_RD_ANS: assert property ((!cs_n && ce && rd_n) [*8] ##1
    (!cs_n && ce && !rd_n) [*8] |=> data_oe)
    else $error("read gave no answer");
  AST_RD_HOLD: assert property ((!cs_n && ce && !rd_n) [*8] |=> $stable(data_out))
    else $error("read data moved during strobe");
  AST_NO_FALL: assert property (rd_n [*8] |=> $stable(data_out))
    else $error("read data moved without strobe");
  AST_XTAL: assert property (xtal_in [*6] |=> !xtal_out)
    else $error("oscillator output not inverted");
endmodule // rtc_bus_monitor

// ### verilog/bcd_rtc_with_nibble_cpu_port.sv
// Overview of operation
// - Accesses count only while chip select is low and chip enable is high.
// - A falling read strobe puts the addressed nibble on the data lines.
// - Both the falling and the rising write strobe store the data nibble.
// - Address inputs are forced to zero while chip enable is low.
// - Data inputs are forced to zero while chip enable is low.
// - Timer output runs as a periodic timer or as a watchdog.
// - With chip enable low the timer halts and its output stays inactive.
// - The interrupt output carries periodic and alarm-match interrupts.
// - The interrupt output keeps working while chip enable is low.
// - Four-bit data bus and four-bit address bus give sixteen locations.
// - Keeps seconds to year, day of week, and an hour and minute alarm.
// - Hour counter runs in twelve-hour or twenty-four-hour format.
// - Leap years are found automatically and February gets its 29th day.
// - All clock and alarm values are kept and read as BCD digits.
// - Adjust rounds to the nearest minute: below thirty clears, else advances.
// - A flag records that the time is untrustworthy, e.g. oscillator stop.
// - Interrupt flags are readable and an inhibit bit blocks the output.
// - The timer counts ticks derived internally from the time base.
module bcd_rtc_with_nibble_cpu_port
  import rtc_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Processor port.
  input wire logic cs_n,
  input wire logic ce,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr_in,
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic data_oe,
  // Open-drain style outputs, low when active.
  output logic irq_out_n,
  output logic timer_out_n,
  // Oscillator.
  input wire logic xtal_in,
  output logic xtal_out
);

  // =========================================================================
  // Pin synchronisers and time base
  // =========================================================================
  bus_pins_s pin_raw, pin_s;
  logic xtal_s, xtal_prev_q, xtal_rise, sec_tick, fast_tick, osc_stopped;

  assign pin_raw = '{cs_n: cs_n, ce: ce, rd_n: rd_n, wr_n: wr_n,
                     addr: addr_in, data: data_in};

  pin_sync #(.WIDTH($bits(bus_pins_s)), .RST_VAL(BUS_IDLE)) u_bus_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(pin_raw),
    .level_out(pin_s)
  );

  pin_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_xtal_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(xtal_in),
    .level_out(xtal_s)
  );

  assign xtal_rise = xtal_s & ~xtal_prev_q;

  xtal_timebase u_timebase (
    .sys_clk(sys_clk),
    .rst(rst),
    .xtal_rise(xtal_rise),
    .sec_tick(sec_tick),
    .fast_tick(fast_tick),
    .osc_stopped(osc_stopped)
  );

  // =========================================================================
  // Bus decode
  // =========================================================================
  logic rd_prev_q, wr_prev_q;
  logic access_ok, rd_fall, wr_edge, wr_b0, wr_b1, kick;
  logic [3:0] addr_g, data_g, rd_nib;
  logic ctrl_wr, mode_wr, stat_wr, adj_pulse;
  logic [3:0] ctrl_q, mode_q;
  logic bank;

  // Qualified strobes and gated address and data.
  assign access_ok = ~pin_s.cs_n & pin_s.ce;
  assign addr_g = pin_s.ce ? pin_s.addr : 4'h0;
  assign data_g = pin_s.ce ? pin_s.data : 4'h0;
  assign rd_fall = access_ok & rd_prev_q & ~pin_s.rd_n;
  assign wr_edge = access_ok & (wr_prev_q != pin_s.wr_n);
  assign bank = ctrl_q[CTRL_BANK];
  assign wr_b0 = wr_edge & ~bank;
  assign wr_b1 = wr_edge & bank;
  assign ctrl_wr = wr_edge & (addr_g == OFS_CTRL);
  assign mode_wr = wr_edge & (addr_g == OFS_MODE);
  assign stat_wr = wr_edge & (addr_g == OFS_STAT);
  assign adj_pulse = ctrl_wr & data_g[CTRL_ADJ];
  assign kick = rd_fall | wr_edge;

  // =========================================================================
  // Calendar helpers
  // =========================================================================
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Year divisible by four, worked out on the BCD digits.
  function automatic logic is_leap(input logic [7:0] y);
    logic even_u, quad_u;
    even_u = (y[3:0] == 4'h0) | (y[3:0] == 4'h4) | (y[3:0] == 4'h8);
    quad_u = (y[3:0] == 4'h2) | (y[3:0] == 4'h6);
    return y[4] ? quad_u : even_u;
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic lp);
    logic [7:0] d;
    d = 8'h31;
    if (m == 8'h02) d = lp ? 8'h29 : 8'h28;
    if ((m == 8'h04) | (m == 8'h06) | (m == 8'h09) | (m == 8'h11)) d = 8'h30;
    return d;
  endfunction

  // =========================================================================
  // Time counters and processor writes
  // =========================================================================
  time_s time_q, t_d;
  logic [3:0] alarm_q [4];
  logic min_step, hr_step, day_step, mon_step, yr_step, alm_match;
  logic [7:0] hr12, alm_min, alm_hr;

  assign alm_min = {alarm_q[1], alarm_q[0]};
  assign alm_hr = {alarm_q[3], alarm_q[2]};
  assign hr12 = {3'b000, time_q.hour[4:0]};

  // Carry chain from seconds to years; writes overlay the counted value.
  always_comb begin
    t_d = time_q;
    min_step = (sec_tick & (time_q.sec == 8'h59)) | (adj_pulse & (time_q.sec >= 8'h30));
    hr_step = min_step & (time_q.min == 8'h59);
    day_step = 1'b0;
    if (adj_pulse | sec_tick) begin
      t_d.sec = (adj_pulse | (time_q.sec == 8'h59)) ? 8'h00 : bcd_inc(time_q.sec);
    end
    if (min_step) t_d.min = (time_q.min == 8'h59) ? 8'h00 : bcd_inc(time_q.min);
    if (hr_step) begin
      if (mode_q[MODE_H24]) begin
        day_step = (time_q.hour == 8'h23);
        t_d.hour = day_step ? 8'h00 : bcd_inc(time_q.hour);
      end else if (hr12 == 8'h11) begin
        day_step = time_q.hour[HR_PM_BIT];
        t_d.hour = {2'b00, ~time_q.hour[HR_PM_BIT], 5'h12};
      end else if (hr12 == 8'h12) begin
        t_d.hour = {2'b00, time_q.hour[HR_PM_BIT], 5'h01};
      end else begin
        t_d.hour = bcd_inc(time_q.hour);
      end
    end
    mon_step = day_step & (time_q.day == month_days(time_q.mon, is_leap(time_q.year)));
    yr_step = mon_step & (time_q.mon == 8'h12);
    if (day_step) begin
      t_d.day = mon_step ? 8'h01 : bcd_inc(time_q.day);
      t_d.dow = (time_q.dow == 3'h6) ? 3'h0 : time_q.dow + 3'h1;
    end
    if (mon_step) t_d.mon = yr_step ? 8'h01 : bcd_inc(time_q.mon);
    if (yr_step) t_d.year = (time_q.year == 8'h99) ? 8'h00 : bcd_inc(time_q.year);
    if (wr_b0) begin
      unique case (addr_g)
        OFS_SEC1: t_d.sec[3:0] = data_g;
        OFS_SEC10: t_d.sec[7:4] = {1'b0, data_g[2:0]};
        OFS_MIN1: t_d.min[3:0] = data_g;
        OFS_MIN10: t_d.min[7:4] = {1'b0, data_g[2:0]};
        OFS_HR1: t_d.hour[3:0] = data_g;
        OFS_HR10: t_d.hour[7:4] = {2'b00, data_g[1:0]};
        OFS_DOW: t_d.dow = data_g[2:0];
        OFS_DAY1: t_d.day[3:0] = data_g;
        OFS_DAY10: t_d.day[7:4] = {2'b00, data_g[1:0]};
        OFS_MON1: t_d.mon[3:0] = data_g;
        OFS_MON10: t_d.mon[7:4] = {3'b000, data_g[0]};
        OFS_YR1: t_d.year[3:0] = data_g;
        OFS_YR10: t_d.year[7:4] = data_g;
        default: t_d = t_d;
      endcase
    end
  end

  // Alarm compares the time about to be entered at a minute boundary.
  assign alm_match = min_step & mode_q[MODE_ALM_EN] & (t_d.min == alm_min) &
                     (t_d.hour == alm_hr);

  // Time, alarm and control storage.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      time_q <= TIME_RST;
      for (int i = 0; i < 4; i++) alarm_q[i] <= ALARM_RST;
      ctrl_q <= CTRL_RST;
      mode_q <= MODE_RST;
    end else begin
      time_q <= t_d;
      if (wr_b1 && (addr_g[3:2] == 2'b00)) alarm_q[addr_g[1:0]] <= data_g;
      if (ctrl_wr) ctrl_q <= {data_g[3:2], 1'b0, data_g[0]};
      if (mode_wr) mode_q <= data_g;
    end
  end

  // =========================================================================
  // Status flags and interrupt output
  // =========================================================================
  logic invalid_q, alm_flag_q, per_flag_q, tmr_flag_q, tmr_fire;
  logic invalid_d, alm_flag_d, per_flag_d, tmr_flag_d, per_set, irq_n_q;

  // Hardware set wins over a write-one clear in the same cycle.
  assign per_set = mode_q[MODE_PER_MIN] ? min_step : sec_tick;
  assign invalid_d = osc_stopped | (invalid_q & ~(stat_wr & data_g[STAT_INVALID]));
  assign alm_flag_d = alm_match | (alm_flag_q & ~(stat_wr & data_g[STAT_ALM]));
  assign per_flag_d = per_set | (per_flag_q & ~(stat_wr & data_g[STAT_PER]));
  assign tmr_flag_d = tmr_fire | (tmr_flag_q & ~(stat_wr & data_g[STAT_TMR]));

  // Flags run without regard to chip enable so interrupts survive backup.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      invalid_q <= 1'b1;
      alm_flag_q <= 1'b0;
      per_flag_q <= 1'b0;
      tmr_flag_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      invalid_q <= invalid_d;
      alm_flag_q <= alm_flag_d;
      per_flag_q <= per_flag_d;
      tmr_flag_q <= tmr_flag_d;
      irq_n_q <= ~((alm_flag_d | per_flag_d) & ~ctrl_q[CTRL_INH]);
    end
  end

  // =========================================================================
  // Timer: periodic or watchdog, counting 64 Hz ticks
  // =========================================================================
  tmr_state_e tmr_q, tmr_d;
  logic [7:0] tmr_load_q, tmr_cnt_q, tmr_cnt_d;
  logic tmr_live;

  assign tmr_live = pin_s.ce & ctrl_q[CTRL_TMR_EN];
  assign tmr_fire = (tmr_q == TMR_RUN) & tmr_live & fast_tick & (tmr_cnt_q == 8'h00);

  // Next state; losing chip enable forces the idle state.
  always_comb begin
    tmr_d = tmr_q;
    tmr_cnt_d = tmr_cnt_q;
    unique case (tmr_q)
      TMR_IDLE: begin
        tmr_d = TMR_RUN;
        tmr_cnt_d = tmr_load_q;
      end
      TMR_RUN: begin
        if (mode_q[MODE_WDOG] & kick) begin
          tmr_cnt_d = tmr_load_q;
        end else if (tmr_fire) begin
          tmr_d = TMR_FIRED;
        end else if (fast_tick) begin
          tmr_cnt_d = tmr_cnt_q - 8'h01;
        end
      end
      TMR_FIRED: begin
        if (mode_q[MODE_WDOG] ? kick : fast_tick) begin
          tmr_d = TMR_RUN;
          tmr_cnt_d = tmr_load_q;
        end
      end
      default: tmr_d = TMR_IDLE;
    endcase
    if (!tmr_live) tmr_d = TMR_IDLE;
  end

  // Timer storage.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmr_q <= TMR_IDLE;
      tmr_cnt_q <= TMR_RST;
      tmr_load_q <= TMR_RST;
    end else begin
      tmr_q <= tmr_d;
      tmr_cnt_q <= tmr_cnt_d;
      if (wr_b1 && (addr_g == OFS_TMR_LO)) tmr_load_q[3:0] <= data_g;
      if (wr_b1 && (addr_g == OFS_TMR_HI)) tmr_load_q[7:4] <= data_g;
    end
  end

  // =========================================================================
  // Read multiplexer and output stage
  // =========================================================================
  logic [3:0] rd_b0 [16];
  logic [3:0] rd_b1 [16];
  logic [3:0] stat_rd, data_out_q;
  logic data_oe_q, timer_n_q, xtal_out_q;

  assign stat_rd = {tmr_flag_q, per_flag_q, alm_flag_q, invalid_q};

  // Bank 0: time and calendar digits, then shared control locations.
  assign rd_b0[0] = time_q.sec[3:0];
  assign rd_b0[1] = time_q.sec[7:4];
  assign rd_b0[2] = time_q.min[3:0];
  assign rd_b0[3] = time_q.min[7:4];
  assign rd_b0[4] = time_q.hour[3:0];
  assign rd_b0[5] = time_q.hour[7:4];
  assign rd_b0[6] = {1'b0, time_q.dow};
  assign rd_b0[7] = time_q.day[3:0];
  assign rd_b0[8] = time_q.day[7:4];
  assign rd_b0[9] = time_q.mon[3:0];
  assign rd_b0[10] = time_q.mon[7:4];
  assign rd_b0[11] = time_q.year[3:0];
  assign rd_b0[12] = time_q.year[7:4];

  // Bank 1: alarm digits, timer reload, unused locations read zero.
  for (genvar i = 0; i < 13; i++) begin : g_bank1
    if (i < 4) begin : g_alm
      assign rd_b1[i] = alarm_q[i];
    end else if (i == 4) begin : g_tlo
      assign rd_b1[i] = tmr_load_q[3:0];
    end else if (i == 5) begin : g_thi
      assign rd_b1[i] = tmr_load_q[7:4];
    end else begin : g_zero
      assign rd_b1[i] = 4'h0;
    end
  end

  // Control, mode and status sit in both banks.
  for (genvar i = 13; i < 16; i++) begin : g_shared
    assign rd_b0[i] = (i == 13) ? ctrl_q : ((i == 14) ? mode_q : stat_rd);
    assign rd_b1[i] = rd_b0[i];
  end

  assign rd_nib = bank ? rd_b1[addr_g] : rd_b0[addr_g];

  // Output flops; the data lines are driven only through a valid read.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      xtal_prev_q <= 1'b0;
      data_out_q <= 4'h0;
      data_oe_q <= 1'b0;
      timer_n_q <= 1'b1;
      xtal_out_q <= 1'b1;
    end else begin
      rd_prev_q <= pin_s.rd_n;
      wr_prev_q <= pin_s.wr_n;
      xtal_prev_q <= xtal_s;
      if (rd_fall) data_out_q <= rd_nib;
      data_oe_q <= access_ok & ~pin_s.rd_n & (rd_fall | data_oe_q);
      timer_n_q <= (tmr_d != TMR_FIRED);
      xtal_out_q <= ~xtal_s;
    end
  end

  assign data_out = data_out_q;
  assign data_oe = data_oe_q;
  assign irq_out_n = irq_n_q;
  assign timer_out_n = timer_n_q;
  assign xtal_out = xtal_out_q;

endmodule // bcd_rtc_with_nibble_cpu_port

// ### verilog/pin_sync.sv
module pin_sync
  import rtc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Raw pins and filtered levels.
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // =========================================================================
  // Three stages; a level is taken only once stages two and three agree.
  // =========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Per-bit agreement filter.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
  end

  assign level_out = lvl_q;

endmodule // pin_sync

// ### verilog/rtc_pkg.sv
package rtc_pkg;

  // ==========================================================================
  // Clocks and time base
  // ==========================================================================
  localparam int CLK_HZ = 10_000_000;
  localparam int XTAL_HZ = 32_768;
  localparam int DIV_W = $clog2(XTAL_HZ);
  localparam int FAST_W = 9;
  localparam int STOP_US = 100;
  localparam int STOP_CYC = STOP_US * (CLK_HZ / 1_000_000);

  // ==========================================================================
  // Location offsets, bank 0 (time and calendar) and bank 1 (alarm, timer)
  // ==========================================================================
  localparam logic [3:0] OFS_SEC1 = 4'h0;
  localparam logic [3:0] OFS_SEC10 = 4'h1;
  localparam logic [3:0] OFS_MIN1 = 4'h2;
  localparam logic [3:0] OFS_MIN10 = 4'h3;
  localparam logic [3:0] OFS_HR1 = 4'h4;
  localparam logic [3:0] OFS_HR10 = 4'h5;
  localparam logic [3:0] OFS_DOW = 4'h6;
  localparam logic [3:0] OFS_DAY1 = 4'h7;
  localparam logic [3:0] OFS_DAY10 = 4'h8;
  localparam logic [3:0] OFS_MON1 = 4'h9;
  localparam logic [3:0] OFS_MON10 = 4'hA;
  localparam logic [3:0] OFS_YR1 = 4'hB;
  localparam logic [3:0] OFS_YR10 = 4'hC;
  localparam logic [3:0] OFS_CTRL = 4'hD;
  localparam logic [3:0] OFS_MODE = 4'hE;
  localparam logic [3:0] OFS_STAT = 4'hF;
  localparam logic [3:0] OFS_TMR_LO = 4'h4;
  localparam logic [3:0] OFS_TMR_HI = 4'h5;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int CTRL_BANK = 0;
  localparam int CTRL_ADJ = 1;
  localparam int CTRL_INH = 2;
  localparam int CTRL_TMR_EN = 3;
  localparam int MODE_H24 = 0;
  localparam int MODE_WDOG = 1;
  localparam int MODE_PER_MIN = 2;
  localparam int MODE_ALM_EN = 3;
  localparam int STAT_INVALID = 0;
  localparam int STAT_ALM = 1;
  localparam int STAT_PER = 2;
  localparam int STAT_TMR = 3;
  localparam int HR_PM_BIT = 5;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] MODE_RST = 4'h1;
  localparam logic [7:0] TMR_RST = 8'hFF;
  localparam logic [3:0] ALARM_RST = 4'h0;

  // ==========================================================================
  // Carriers and states
  // ==========================================================================
  typedef struct packed {
    logic cs_n;
    logic ce;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [3:0] data;
  } bus_pins_s;

  localparam bus_pins_s BUS_IDLE = '{cs_n: 1'b1, ce: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                                     addr: 4'h0, data: 4'h0};

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] mon;
    logic [7:0] day;
    logic [2:0] dow;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } time_s;

  localparam time_s TIME_RST = '{year: 8'h00, mon: 8'h01, day: 8'h01, dow: 3'h0,
                                 hour: 8'h00, min: 8'h00, sec: 8'h00};

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN = 2'b01,
    TMR_FIRED = 2'b11
  } tmr_state_e;

endpackage

// ### verilog/xtal_timebase.sv
module xtal_timebase
  import rtc_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Oscillator edge in, ticks out.
  input wire logic xtal_rise,
  output logic sec_tick,
  output logic fast_tick,
  output logic osc_stopped
);

  logic [DIV_W-1:0] div_q;
  logic [$clog2(STOP_CYC+1)-1:0] idle_q;
  logic sec_q, fast_q, stop_q;

  // =========================================================================
  // Crystal divider: one-second tick and a 64 Hz tick for the timer.
  // =========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      sec_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      div_q <= xtal_rise ? div_q + 1'b1 : div_q;
      sec_q <= xtal_rise & (&div_q);
      fast_q <= xtal_rise & (&div_q[FAST_W-1:0]);
    end
  end

  // =========================================================================
  // Stop watch: no crystal edge for the stop time flags a halted oscillator.
  // =========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_q <= '0;
      stop_q <= 1'b0;
    end else begin
      idle_q <= xtal_rise ? '0 : (stop_q ? idle_q : idle_q + 1'b1);
      stop_q <= ~xtal_rise & (stop_q | (idle_q == STOP_CYC[$bits(idle_q)-1:0]));
    end
  end

  assign sec_tick = sec_q;
  assign fast_tick = fast_q;
  assign osc_stopped = stop_q;

endmodule // xtal_timebase
